// ### upsp_mem_model.sv
// configuration memory model
`timescale 1ns/1ps
`default_nettype none
module upsp_mem_model (
  input  wire logic        sel_i,
  input  wire logic        sck_i,
  input  wire logic [15:0] word_i,
  input  wire logic        di_i,
  output var  logic        dq_o,
  output var  logic [8:0]  cmd_o
);
  logic [4:0] n = 5'h00;
  initial dq_o = 1'b1;
  initial cmd_o = 9'h000;
  // capture the command bits on rising clock, as a real memory would
  always @(posedge sck_i)
    if (sel_i && n < 5'h09)
      cmd_o <= {cmd_o[7:0], di_i};
  always @(posedge sck_i or negedge sel_i)
    n <= sel_i ? n + 5'h01 : 5'h00;
  // msb first after the 9 command bits; pull-up level when idle
  always @(negedge sck_i or negedge sel_i)
    dq_o <= (sel_i && n > 5'h08 && n < 5'h19) ? word_i[5'h18 - n] : 1'b1;
endmodule
`default_nettype wire

// ### upsp_monitor.sv
// assertion checker
`timescale 1ns/1ps
`default_nettype none
module upsp_monitor (
  input wire logic mclk_i, rst_b_i, bus_suspend_i, configured_i, host_power_sense_i,
  input wire logic power_enable_n_o, suspend_n_o, cfg_mem_select_o, cfg_loaded_o,
  input wire logic cfg_mem_select_oe_n_o, cfg_mem_clock_oe_n_o, cfg_mem_data_oe_n_o,
  input wire logic [15:0] cfg_word_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_go;
    ##[1:4] cfg_mem_select_o;
  endsequence
  AST_ON: assert property (
    !power_enable_n_o |-> $past(configured_i && !bus_suspend_i)) else $error("pwr on");
  AST_OFF: assert property (
    $past(bus_suspend_i || !configured_i) |-> power_enable_n_o) else $error("pwr off");
  AST_SUSP: assert property ($past(bus_suspend_i) |-> !suspend_n_o) else $error("susp");
  AST_SENSE: assert property (
    $past(cfg_loaded_o && cfg_word_o[0] && !host_power_sense_i) |-> !suspend_n_o)
    else $error("sense");
  AST_NORM: assert property (
    $past(!bus_suspend_i && (host_power_sense_i || !cfg_word_o[0])) |-> suspend_n_o)
    else $error("norm");
  // reset must not mask these two, so they override the default disable
  AST_SEL_Z: assert property (disable iff (1'b0)
    !rst_b_i |-> cfg_mem_select_oe_n_o && cfg_mem_data_oe_n_o) else $error("sel z");
  AST_CLK_Z: assert property (disable iff (1'b0)
    !rst_b_i |-> cfg_mem_clock_oe_n_o) else $error("clk z");
  AST_READ: assert property ($rose(rst_b_i) |-> s_go) else $error("read");
endmodule
bind upsp_top upsp_monitor i_mon (.*);
`default_nettype wire

// ### upsp_pkg.sv
// package for the usb power state pins block
package upsp_pkg;

  // serial clock divider: half period in mclk cycles
  localparam int unsigned SCLK_HALF_NS   = 1000;
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam logic [7:0]  SCLK_HALF_CYC  = 8'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  SCLK_CNT_ZERO  = 8'h00;

  // configuration read: one 16-bit word at address 0
  localparam logic [2:0]  CMD_READ       = 3'h6;
  localparam logic [5:0]  CFG_ADDR       = 6'h00;
  localparam logic [4:0]  CMD_BITS       = 5'h09;
  localparam logic [4:0]  DATA_BITS      = 5'h10;
  localparam logic [4:0]  BIT_CNT_ZERO   = 5'h00;
  localparam int unsigned SENSE_EN_BIT   = 0;

  // pin triplet for a three-state pin; oe_n low means driven
  typedef struct packed {
    logic in;
    logic out;
    logic oe_n;
  } upsp_pin_t;

  // state of the configuration memory reader
  typedef enum logic [3:0] {
    RD_IDLE = 4'b0001,
    RD_CMD  = 4'b0010,
    RD_DATA = 4'b0100,
    RD_DONE = 4'b1000
  } upsp_rd_state_t;

endpackage

// ### upsp_sclk_gen.sv
// serial clock divider for the configuration memory
`timescale 1ns/1ps
`default_nettype none
module upsp_sclk_gen
(
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic run_i,
  output var  logic sclk_o,
  output var  logic rise_o,
  output var  logic fall_o
);

  logic [7:0] cnt_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_reg <= upsp_pkg::SCLK_CNT_ZERO;
      sclk_o  <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_reg <= upsp_pkg::SCLK_CNT_ZERO;
      sclk_o  <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end
    else if (cnt_reg == upsp_pkg::SCLK_HALF_CYC - 8'h01)
    begin
      cnt_reg <= upsp_pkg::SCLK_CNT_ZERO;
      sclk_o  <= ~sclk_o;
      rise_o  <= ~sclk_o;
      fall_o  <= sclk_o;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### upsp_top.sv
// power enable, suspend indication and configuration memory pins
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - power enable low when configured, not suspended
// - power enable high when suspended or unconfigured
// - suspend output low while bus suspended
// - sense low with option forces suspend
// - sense high leaves normal operation
// - sense honoured only if memory setting enables
// - memory select tri-stated during reset
// - memory clock tri-stated in reset, else driven
// - memory data bidirectional, tri-stated in reset
module upsp_top
(
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  input  wire logic              bus_suspend_i,
  input  wire logic              configured_i,
  input  wire logic              host_power_sense_i,
  input  wire logic              cfg_mem_data_i,
  output var  logic              power_enable_n_o,
  output var  logic              suspend_n_o,
  output var  logic              cfg_mem_select_o,
  output var  logic              cfg_mem_select_oe_n_o,
  output var  logic              cfg_mem_clock_o,
  output var  logic              cfg_mem_clock_oe_n_o,
  output var  logic              cfg_mem_data_o,
  output var  logic              cfg_mem_data_oe_n_o,
  output var  logic              cfg_loaded_o,
  output var  logic [15:0]       cfg_word_o
);

  upsp_pkg::upsp_rd_state_t state_reg;
  logic [4:0]  bit_cnt_reg;
  logic [8:0]  cmd_reg;
  logic        sclk;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        run;
  logic        sense_en;
  logic        suspended;

  assign run = (state_reg == upsp_pkg::RD_CMD) || (state_reg == upsp_pkg::RD_DATA);

  upsp_sclk_gen u_sclk
  (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .run_i   (run),
    .sclk_o  (sclk),
    .rise_o  (sclk_rise),
    .fall_o  (sclk_fall)
  );

  // after reset release the reader starts by itself
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg   <= upsp_pkg::RD_IDLE;
      bit_cnt_reg <= upsp_pkg::BIT_CNT_ZERO;
      cmd_reg     <= 9'h000;
      cfg_word_o  <= 16'h0000;
    end
    else
    begin
      unique case (state_reg)
        upsp_pkg::RD_IDLE:
        begin
          state_reg   <= upsp_pkg::RD_CMD;
          bit_cnt_reg <= upsp_pkg::CMD_BITS;
          cmd_reg     <= {upsp_pkg::CMD_READ, upsp_pkg::CFG_ADDR};
        end
        upsp_pkg::RD_CMD:
        begin
          // shift out on falling edge so the memory samples on rising
          if (sclk_fall)
          begin
            cmd_reg     <= {cmd_reg[7:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg - 5'h01;
            if (bit_cnt_reg == 5'h01)
            begin
              state_reg   <= upsp_pkg::RD_DATA;
              bit_cnt_reg <= upsp_pkg::DATA_BITS;
            end
          end
        end
        upsp_pkg::RD_DATA:
        begin
          if (sclk_rise)
          begin
            cfg_word_o  <= {cfg_word_o[14:0], cfg_mem_data_i};
            bit_cnt_reg <= bit_cnt_reg - 5'h01;
            if (bit_cnt_reg == 5'h01)
            begin
              state_reg <= upsp_pkg::RD_DONE;
            end
          end
        end
        upsp_pkg::RD_DONE:
        begin
          state_reg <= upsp_pkg::RD_DONE;
        end
      endcase
    end
  end

  // pins float in reset; select and clock driven afterwards, data only in RD_CMD
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cfg_mem_select_o      <= 1'b0;
      cfg_mem_select_oe_n_o <= 1'b1;
      cfg_mem_clock_o       <= 1'b0;
      cfg_mem_clock_oe_n_o  <= 1'b1;
      cfg_mem_data_o        <= 1'b0;
      cfg_mem_data_oe_n_o   <= 1'b1;
      cfg_loaded_o          <= 1'b0;
    end
    else
    begin
      cfg_mem_select_o      <= run;
      cfg_mem_select_oe_n_o <= 1'b0;
      cfg_mem_clock_o       <= sclk;
      cfg_mem_clock_oe_n_o  <= 1'b0;
      cfg_mem_data_o        <= cmd_reg[8];
      // data released while the memory answers
      cfg_mem_data_oe_n_o   <= (state_reg != upsp_pkg::RD_CMD);
      cfg_loaded_o          <= (state_reg == upsp_pkg::RD_DONE);
    end
  end

  // sense option comes from the loaded word; off until load ends
  assign sense_en  = cfg_loaded_o && cfg_word_o[upsp_pkg::SENSE_EN_BIT];
  // low sense forces suspend, high leaves bus state alone
  assign suspended = bus_suspend_i || (sense_en && !host_power_sense_i);

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      power_enable_n_o <= 1'b1;
      suspend_n_o      <= 1'b1;
    end
    else
    begin
      // unconfigured counts until both host and memory load are done
      power_enable_n_o <= suspended || !configured_i || !cfg_loaded_o;
      suspend_n_o      <= !suspended;
    end
  end

endmodule
`default_nettype wire

// ### upsp_top_bench.sv
// testbench
`timescale 1ns/1ps
`default_nettype none
module upsp_top_bench;
  logic mclk_i = 0, rst_b_i = 1, bus_suspend_i = 0, configured_i = 1, host_power_sense_i = 1;
  logic power_enable_n_o, suspend_n_o, cfg_mem_select_o, cfg_mem_select_oe_n_o, dq;
  logic cfg_mem_clock_o, cfg_mem_clock_oe_n_o, cfg_mem_data_o, cfg_mem_data_oe_n_o;
  logic cfg_loaded_o;
  logic [8:0] cmd;
  logic [15:0] cfg_word_o, word;
  wire cfg_mem_data_i = cfg_mem_data_oe_n_o ? dq : cfg_mem_data_o;
  wire [15:0] pins = 16'({power_enable_n_o, suspend_n_o, cfg_mem_select_oe_n_o,
    cfg_mem_clock_oe_n_o, cfg_mem_data_oe_n_o});
  int n_fail = 0, comparisons = 0;
  always #10 mclk_i = ~mclk_i;
  upsp_top i_dut (.*);
  upsp_mem_model i_mem (.sel_i(cfg_mem_select_o & ~cfg_mem_select_oe_n_o),
    .sck_i(cfg_mem_clock_o), .word_i(word), .di_i(cfg_mem_data_o), .dq_o(dq),
    .cmd_o(cmd));
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic boot(input logic [15:0] w);
    rst_b_i = 0;
    word = w;
    step(5);
    chk("reset pins", 16'h001f, pins);
    rst_b_i = 1;
    repeat (3000)
      if (cfg_loaded_o !== 1'b1)
        step(1);
    chk("word", w, cfg_word_o);
    chk("cmd", 16'h0180, 16'(cmd));
    $display("boot end");
  endtask
  task automatic put(input logic s, c, p, input logic [15:0] e);
    bus_suspend_i = s;
    configured_i = c;
    host_power_sense_i = p;
    step(2);
    chk("pins", e, pins);
  endtask
  task automatic t_power;
    put(1'b0, 1'b1, 1'b1, 16'h0009);
    put(1'b1, 1'b1, 1'b1, 16'h0011);
    put(1'b0, 1'b0, 1'b1, 16'h0019);
    put(1'b0, 1'b1, 1'b0, 16'h0011);
    put(1'b0, 1'b1, 1'b1, 16'h0009);
    $display("power end");
  endtask
  task automatic t_off;
    put(1'b0, 1'b1, 1'b0, 16'h0009);
    $display("sense off end");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #1;
    boot(16'hc3a5);
    t_power;
    boot(16'h3c5a);
    t_off;
    report_and_stop;
  end
  // two full reads take about 4900 cycles
  initial
  begin
    #400000;
    n_fail++;
    report_and_stop;
  end
endmodule
`default_nettype wire
